// file: verilog/ibl_pkg.sv
// ----------------------------------------------------------------------------
// Inband loopback pattern detector constants
// ----------------------------------------------------------------------------
package ibl_pkg;

  // --------------------------------------------------------------------------
  // Register indices and byte addresses (byte address is four times index)
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] IDX_LEN_CFG = 12'h04c;       // Length configuration
  localparam logic [11:0] IDX_IRQ_EN_STS = 12'h04d;    // Enable / status
  localparam logic [11:0] IDX_ACT_PAT = 12'h04e;       // Activate pattern
  localparam logic [11:0] IDX_DEACT_PAT = 12'h04f;     // Deactivate pattern
  localparam logic [11:0] ADDR_LEN_CFG = {IDX_LEN_CFG[9:0], 2'h0};
  localparam logic [11:0] ADDR_IRQ_EN_STS = {IDX_IRQ_EN_STS[9:0], 2'h0};
  localparam logic [11:0] ADDR_ACT_PAT = {IDX_ACT_PAT[9:0], 2'h0};
  localparam logic [11:0] ADDR_DEACT_PAT = {IDX_DEACT_PAT[9:0], 2'h0};
  localparam logic [11:0] ADDR_EVT_STS = 12'h200;      // Sticky change events
  localparam logic [11:0] ADDR_EVT_MASK = 12'h204;     // Event mask

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int CFG_RSVD = 7;          // Reserved, kept writable
  localparam int CFG_DSEL_HI = 3;       // deact_len_sel_hi
  localparam int CFG_DSEL_LO = 2;       // deact_len_sel_lo
  localparam int CFG_ASEL_HI = 1;       // act_len_sel_hi
  localparam int CFG_ASEL_LO = 0;       // act_len_sel_lo
  localparam int IES_ACT_SEEN = 7;      // act_pattern_seen_interval
  localparam int IES_DEACT_SEEN = 6;    // deact_pattern_seen_interval
  localparam int IES_ACT_EN = 5;        // act_change_irq_en
  localparam int IES_DEACT_EN = 4;      // deact_change_irq_en
  localparam int IES_ACT_FLAG = 3;      // act_change_irq_flag
  localparam int IES_DEACT_FLAG = 2;    // deact_change_irq_flag
  localparam int IES_ACT_STATE = 1;     // act_detect_state
  localparam int IES_DEACT_STATE = 0;   // deact_detect_state
  localparam int PAT_ACT = 1;           // Per-pattern index of activate
  localparam int PAT_DEACT = 0;         // Per-pattern index of deactivate

  // --------------------------------------------------------------------------
  // Reset values, encodings and timing
  // --------------------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] LEN_M1_BASE = 3'h4;        // Five bits minus one
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] HIST_FULL = 4'h8;          // Bits to fill history
  localparam real INTERVAL_MS = 39.8;               // Observation interval
  localparam real CLK_HZ = 10000000.0;
  localparam int INTERVAL_CYC = int'(INTERVAL_MS * CLK_HZ / 1000.0);

endpackage : ibl_pkg

// file: verilog/ibl_detector.sv
`timescale 1ns/1ps
// Operation
// - Two-bit selector picks five to eight bits
// - E1 mode holds all four registers reset
// - Seen bits report presence over last interval
// - Activate enable gates activate changes onto interrupt
// - Deactivate enable gates deactivate changes onto interrupt
// - Cause bits mark changes that raised interrupt
// - State bits show present detect state
// - Pattern bit seven matches earliest received bit
module ibl_detector
  import ibl_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = INTERVAL_CYC,  // Observation length
  parameter int CNT_W = 20                                 // Interval counter
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic line_standard_select,
  input wire logic rx_bit,
  input wire logic rx_bit_en,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cpu_irq_n,
  output logic irq
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic hold;                                  // E1 mode keeps detection and four registers in reset
  logic aw_held_r, aw_held_nxt;                // Write address captured
  logic w_held_r, w_held_nxt;                  // Write data captured
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [7:0] w_data_r, w_data_nxt;            // Only the low lane is used
  logic w_lane_r, w_lane_nxt;                  // Low byte strobe
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic aw_hs, w_hs, ar_hs, do_wr;             // Channel handshakes
  logic rd_hit;                                // Read address decodes
  logic [7:0] rd_byte;                         // Selected register value
  logic [7:0] cfg_r, cfg_nxt;                  // Length configuration
  logic [1:0] en_r, en_nxt;                    // Change interrupt enables
  logic [1:0] flag_r, flag_nxt;                // Change interrupt causes
  logic [7:0] pat_r [2], pat_nxt [2];          // Programmed patterns
  logic [1:0] sts_r, sts_nxt;                  // Sticky change events
  logic [1:0] mask_r, mask_nxt;                // Event mask
  logic rd_clear;                              // Status register being read
  logic [8:0] hist_r, hist_nxt;                // Received bits, newest at 0
  logic [3:0] fill_r, fill_nxt;                // Valid history depth
  logic [CNT_W-1:0] int_cnt_r, int_cnt_nxt;
  logic int_end;                               // Last cycle of interval
  logic [1:0] hit_r, hit_nxt;                  // Aligned pattern seen
  logic [1:0] err_r, err_nxt;                  // Period broken
  logic [1:0] seen_r, seen_nxt;                // Presence over last interval
  logic [1:0] state_r, state_nxt;              // Detect state
  logic [1:0] change;                          // Detect state toggles
  logic [2:0] len_m1 [2];                      // Pattern length minus one
  logic [7:0] new_win;                         // Eight most recent bits

  assign hold = line_standard_select;

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  // Address and data may arrive in either order; each is parked until both
  // are present, so a write always completes exactly one cycle later.
  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign do_wr = aw_held_r && w_held_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // Read decode; unused bits read as zero
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = REG_RESET;
    unique case (s_axi_araddr)
      ADDR_LEN_CFG: rd_byte = {cfg_r[CFG_RSVD], 3'h0, cfg_r[3:0]};
      ADDR_IRQ_EN_STS: rd_byte = {seen_r, en_r, flag_r, state_r};
      ADDR_ACT_PAT: rd_byte = pat_r[PAT_ACT];
      ADDR_DEACT_PAT: rd_byte = pat_r[PAT_DEACT];
      ADDR_EVT_STS: rd_byte = {6'h00, sts_r};
      ADDR_EVT_MASK: rd_byte = {6'h00, mask_r};
      default: rd_hit = 1'b0;
    endcase
  end

  // Next state of the bus channels
  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_lane_nxt = w_lane_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (aw_hs) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (w_hs) begin
      w_held_nxt = 1'b1;
      w_data_nxt = s_axi_wdata[7:0];
      w_lane_nxt = s_axi_wstrb[0];
    end
    if (do_wr) begin
      // Both halves present: commit and answer
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      unique case (aw_addr_r)
        ADDR_LEN_CFG, ADDR_IRQ_EN_STS, ADDR_ACT_PAT, ADDR_DEACT_PAT,
        ADDR_EVT_STS, ADDR_EVT_MASK: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (ar_hs) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = {24'h000000, rd_byte};
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // Bus channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= REG_RESET;
      w_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_lane_r <= w_lane_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  assign rd_clear = ar_hs && (s_axi_araddr == ADDR_IRQ_EN_STS);

  // Software writes, read side effects and hardware-set causes
  always_comb begin
    cfg_nxt = cfg_r;
    en_nxt = en_r;
    flag_nxt = flag_r;
    pat_nxt = pat_r;
    sts_nxt = sts_r;
    mask_nxt = mask_r;
    if (do_wr && w_lane_r) begin
      unique case (aw_addr_r)
        ADDR_LEN_CFG: cfg_nxt = {w_data_r[CFG_RSVD], 3'h0, w_data_r[3:0]};
        ADDR_IRQ_EN_STS: en_nxt = w_data_r[IES_ACT_EN:IES_DEACT_EN];
        ADDR_ACT_PAT: pat_nxt[PAT_ACT] = w_data_r;
        ADDR_DEACT_PAT: pat_nxt[PAT_DEACT] = w_data_r;
        ADDR_EVT_STS: sts_nxt = sts_r & ~w_data_r[1:0];   // Write one to clear
        ADDR_EVT_MASK: mask_nxt = w_data_r[1:0];
        default: cfg_nxt = cfg_r;                          // Unmapped: no effect
      endcase
    end
    // Reading the status register drops the causes
    if (rd_clear) begin
      flag_nxt = 2'h0;
    end
    // A change arriving with the clear still wins
    flag_nxt = flag_nxt | (change & en_r);
    sts_nxt = sts_nxt | change;
    // E1 operation forces the configuration, enable, cause and pattern registers back to reset; event status and mask keep their values
    if (hold) begin
      cfg_nxt = REG_RESET;
      en_nxt = 2'h0;
      flag_nxt = 2'h0;
      pat_nxt[PAT_ACT] = REG_RESET;
      pat_nxt[PAT_DEACT] = REG_RESET;
    end
  end

  // Register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= REG_RESET;
      en_r <= 2'h0;
      flag_r <= 2'h0;
      pat_r[PAT_ACT] <= REG_RESET;
      pat_r[PAT_DEACT] <= REG_RESET;
      sts_r <= 2'h0;
      mask_r <= 2'h0;
    end else begin
      cfg_r <= cfg_nxt;
      en_r <= en_nxt;
      flag_r <= flag_nxt;
      pat_r <= pat_nxt;
      sts_r <= sts_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Enabled cause bits drive the low pin, masked sticky events the high one
  assign cpu_irq_n = !(|(flag_r & en_r));
  assign irq = |(sts_r & mask_r);

  // --------------------------------------------------------------------------
  // Pattern detection
  // --------------------------------------------------------------------------
  // Length from the two-bit selector: 00 five bits up to 11 eight bits
  assign len_m1[PAT_ACT] = LEN_M1_BASE + {1'b0, cfg_r[CFG_ASEL_HI:CFG_ASEL_LO]};
  assign len_m1[PAT_DEACT] = LEN_M1_BASE + {1'b0, cfg_r[CFG_DSEL_HI:CFG_DSEL_LO]};
  // Bit seven of a pattern lines up with the oldest bit of the window
  assign new_win = {hist_r[6:0], rx_bit};
  assign int_end = (int_cnt_r == CNT_W'(INTERVAL_CYCLES - 1));

  // A pattern is present over an interval when an aligned copy was seen and
  // every bit repeated the bit one code length earlier. Short codes need no
  // special case because software supplies them doubled.
  always_comb begin
    hist_nxt = hist_r;
    fill_nxt = fill_r;
    hit_nxt = hit_r;
    err_nxt = err_r;
    seen_nxt = seen_r;
    state_nxt = state_r;
    int_cnt_nxt = int_end ? '0 : int_cnt_r + 1'b1;
    if (rx_bit_en) begin
      hist_nxt = {hist_r[7:0], rx_bit};
      fill_nxt = (fill_r == HIST_FULL) ? fill_r : fill_r + 4'h1;
      for (int i = 0; i < 2; i++) begin
        if (fill_r > 4'(len_m1[i]) && rx_bit != hist_r[len_m1[i]]) begin
          err_nxt[i] = 1'b1;
        end
        if (fill_r >= 4'h7 && new_win == pat_r[i]) begin
          hit_nxt[i] = 1'b1;
        end
      end
    end
    if (int_end) begin
      // Close the interval; detect state moves after two agreeing intervals
      for (int i = 0; i < 2; i++) begin
        seen_nxt[i] = hit_r[i] && !err_r[i];
        if (seen_nxt[i] == seen_r[i]) begin
          state_nxt[i] = seen_nxt[i];
        end
      end
      hit_nxt = 2'h0;
      err_nxt = 2'h0;
    end
    if (hold) begin
      hist_nxt = 9'h000;
      fill_nxt = 4'h0;
      hit_nxt = 2'h0;
      err_nxt = 2'h0;
      seen_nxt = 2'h0;
      state_nxt = 2'h0;
      int_cnt_nxt = '0;
    end
  end

  assign change = state_nxt ^ state_r;

  // Detection storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_r <= 9'h000;
      fill_r <= 4'h0;
      hit_r <= 2'h0;
      err_r <= 2'h0;
      seen_r <= 2'h0;
      state_r <= 2'h0;
      int_cnt_r <= '0;
    end else begin
      hist_r <= hist_nxt;
      fill_r <= fill_nxt;
      hit_r <= hit_nxt;
      err_r <= err_nxt;
      seen_r <= seen_nxt;
      state_r <= state_nxt;
      int_cnt_r <= int_cnt_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_both_held;
    aw_held_r && w_held_r;
  endsequence
  sequence s_answer_done;
    bvalid_r ##1 !aw_held_r;
  endsequence
  a_write_answer: assert property (s_both_held |=> s_answer_done)
    else $error("write not answered one cycle after both halves");
  a_hold_reset: assert property (hold |=> cfg_r == 8'h00 && en_r == 2'h0
      && pat_r[1] == 8'h00 && pat_r[0] == 8'h00 && state_r == 2'h0)
    else $error("registers not held reset in E1 mode");
  a_act_irq_set: assert property (!hold && change[1] && en_r[1]
      |=> flag_r[1] && !cpu_irq_n)
    else $error("activate change with enable did not interrupt");
  a_deact_irq_off: assert property (!hold && change[0] && !en_r[0] && !flag_r[0]
      |=> !flag_r[0])
    else $error("disabled deactivate change raised a cause");
  a_read_clears: assert property (!hold && rd_clear && change == 2'h0
      |=> flag_r == 2'h0 && cpu_irq_n)
    else $error("status read did not clear causes");
  a_state_read: assert property (rd_clear |=> rvalid_r
      && rdata_r[1:0] == $past(state_r) && rdata_r[7:6] == $past(seen_r))
    else $error("status read shows wrong state");
  a_interval_seen: assert property (!hold && int_end
      |=> seen_r == ($past(hit_r) & ~$past(err_r)))
    else $error("interval presence wrong");
  a_msb_first: assert property (!hold && rx_bit_en && !int_end && fill_r >= 4'h7
      && {hist_r[6:0], rx_bit} == pat_r[1] |=> hit_r[1])
    else $error("aligned activate pattern not recorded");
  a_len_period: assert property (!hold && rx_bit_en && !int_end && fill_r == 4'h8
      && cfg_r[1:0] == 2'h3 && rx_bit != hist_r[7] |=> err_r[1])
    else $error("eight bit period break not recorded");
endmodule : ibl_detector

// file: testbench/ibl_far_end.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Far-end line equipment: repeats a loopback code bit by bit
// ----------------------------------------------------------------------------
module ibl_far_end (
  input wire logic aclk,
  input wire logic send_on,
  input wire logic all_zero,
  input wire logic [3:0] period,
  output logic rx_bit,
  output logic rx_bit_en
);
  logic [3:0] phase_r; // Position inside one code repetition
  logic tick_r;        // One bit every second clock

  initial begin
    phase_r = 4'h0;
    tick_r = 1'b0;
    rx_bit = 1'b0;
    rx_bit_en = 1'b0;
  end

  // Code 1101 followed by zeros; its mirror image is no rotation of it for
  // lengths six to eight, so a reversed compare would miss it
  always @(posedge aclk) begin
    tick_r <= ~tick_r;
    rx_bit_en <= send_on && tick_r;
    if (send_on && tick_r) begin
      // Earliest code bit leaves first
      rx_bit <= !all_zero && (phase_r == 4'h0 || phase_r == 4'h1 || phase_r == 4'h3);
      phase_r <= (phase_r + 4'h1 == period) ? 4'h0 : phase_r + 4'h1;
    end else begin
      // Unqualified line wanders so no stale level can be trusted
      rx_bit <= ~rx_bit;
    end
  end
endmodule : ibl_far_end

// file: testbench/inband_loopback_code_detector_tb_top.sv
`timescale 1ns/1ps
module inband_loopback_code_detector_tb_top;
  import ibl_pkg::*;
  // --------------------------------------------------------------------------
  // Nets
  // --------------------------------------------------------------------------
  logic aclk, aresetn, e1_mode, rx_bit, rx_bit_en, far_on, far_zero;
  logic [3:0] far_period;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic cpu_irq_n, irq;
  int n_mismatch = 0;
  int compares = 0;

  // Short interval keeps each detection within a few hundred clocks
  ibl_detector #(.INTERVAL_CYCLES(64)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .line_standard_select(e1_mode),
    .rx_bit(rx_bit), .rx_bit_en(rx_bit_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .cpu_irq_n(cpu_irq_n), .irq(irq)
  );

  ibl_far_end far_u (
    .aclk(aclk), .send_on(far_on), .all_zero(far_zero), .period(far_period),
    .rx_bit(rx_bit), .rx_bit_en(rx_bit_en)
  );

  // --------------------------------------------------------------------------
  // Checking and closing
  // --------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  // A wait that runs out ends the run
  task automatic hang(input string nm);
    n_mismatch++;
    $display("CHECK FAILED %s expected response seen none", nm);
    report_and_stop();
  endtask : hang

  // --------------------------------------------------------------------------
  // Bus tasks: sample at the falling edge, release after the taking edge
  // --------------------------------------------------------------------------
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_h, w_h, b_h;
    logic [1:0] rs;
    int n;
    b_h = 1'b0;
    n = 0;
    rs = 2'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b_h && n < 200) begin
      @(negedge aclk);
      aw_h = s_axi_awvalid && s_axi_awready;
      w_h = s_axi_wvalid && s_axi_wready;
      b_h = s_axi_bvalid === 1'b1;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw_h) s_axi_awvalid <= 1'b0;
      if (w_h) s_axi_wvalid <= 1'b0;
      n++;
    end
    s_axi_bready <= 1'b0;
    if (!b_h) hang("bvalid");
    check("bresp", {30'h0, er}, {30'h0, rs});
  endtask : axi_wr

  task automatic axi_rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er,
                        input string nm);
    logic ar_h, r_h;
    logic [31:0] d;
    logic [1:0] rs;
    int n;
    r_h = 1'b0;
    n = 0;
    d = 32'h0;
    rs = 2'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r_h && n < 200) begin
      @(negedge aclk);
      ar_h = s_axi_arvalid && s_axi_arready;
      r_h = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ar_h) s_axi_arvalid <= 1'b0;
      n++;
    end
    s_axi_rready <= 1'b0;
    if (!r_h) hang("rvalid");
    check(nm, {24'h0, e}, d);
    check("rresp", {30'h0, er}, {30'h0, rs});
  endtask : axi_rd

  // Waits for the event interrupt under a bound of 3000 clocks, some 47 intervals
  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    if (irq !== 1'b1) hang("irq");
  endtask : wait_irq

  task automatic e1_pulse();
    @(posedge aclk);
    e1_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    e1_mode <= 1'b0;
  endtask : e1_pulse

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset_map();
    axi_rd(ADDR_LEN_CFG, 8'h00, RESP_OKAY, "len_cfg");
    axi_rd(ADDR_IRQ_EN_STS, 8'h00, RESP_OKAY, "en_sts");
    axi_rd(ADDR_ACT_PAT, 8'h00, RESP_OKAY, "act_pat");
    axi_rd(ADDR_DEACT_PAT, 8'h00, RESP_OKAY, "deact_pat");
    axi_rd(12'h008, 8'h00, RESP_SLVERR, "unmapped");
    axi_wr(12'h008, 8'hff, RESP_SLVERR);
    check("cpu_irq_n", 32'h1, {31'h0, cpu_irq_n});
    $display("reset and map test done");
  endtask : t_reset_map

  // Global mode select holds the registers cleared and discards writes, which still answer OKAY
  task automatic t_e1_hold();
    axi_wr(ADDR_DEACT_PAT, 8'h5a, RESP_OKAY);
    axi_wr(ADDR_LEN_CFG, 8'h8f, RESP_OKAY);
    axi_rd(ADDR_DEACT_PAT, 8'h5a, RESP_OKAY, "deact_pat");
    axi_rd(ADDR_LEN_CFG, 8'h8f, RESP_OKAY, "len_cfg");
    @(posedge aclk);
    e1_mode <= 1'b1;
    axi_rd(ADDR_DEACT_PAT, 8'h00, RESP_OKAY, "deact_pat held");
    axi_wr(ADDR_ACT_PAT, 8'h33, RESP_OKAY);
    axi_rd(ADDR_ACT_PAT, 8'h00, RESP_OKAY, "act_pat held");
    axi_rd(ADDR_LEN_CFG, 8'h00, RESP_OKAY, "len_cfg held");
    @(posedge aclk);
    e1_mode <= 1'b0;
    axi_rd(ADDR_ACT_PAT, 8'h00, RESP_OKAY, "act_pat after");
    $display("mode hold test done");
  endtask : t_e1_hold

  // Each length code detects its own code; enable alternates per pass; the
  // last pass runs a four-bit code doubled in eight-bit mode, enable left on
  task automatic t_lengths();
    logic [7:0] pat;
    logic [1:0] sel;
    logic en;
    int len;
    for (int s = 0; s < 5; s++) begin
      len = (s == 4) ? 4 : 5 + s;
      sel = (s == 4) ? 2'h3 : s[1:0];
      en = (s % 2 == 0);
      for (int i = 0; i < 8; i++) pat[7 - i] = ((i % len) inside {0, 1, 3});
      @(posedge aclk);
      far_on <= 1'b0;
      e1_pulse();
      axi_wr(ADDR_EVT_STS, 8'h03, RESP_OKAY);
      axi_wr(ADDR_LEN_CFG, {4'h0, sel, sel}, RESP_OKAY);
      axi_wr(ADDR_ACT_PAT, pat, RESP_OKAY);
      axi_wr(ADDR_IRQ_EN_STS, {2'h0, en, 5'h00}, RESP_OKAY);
      axi_wr(ADDR_EVT_MASK, 8'h02, RESP_OKAY);
      @(posedge aclk);
      far_period <= len[3:0];
      far_on <= 1'b1;
      wait_irq();
      check("cpu_irq_n", {31'h0, !en}, {31'h0, cpu_irq_n});
      axi_rd(ADDR_IRQ_EN_STS, {2'b10, en, 1'b0, en, 3'b010}, RESP_OKAY, "en_sts");
      check("cpu_irq_n", 32'h1, {31'h0, cpu_irq_n});
      axi_rd(ADDR_EVT_STS, 8'h02, RESP_OKAY, "evt_sts");
      axi_wr(ADDR_EVT_STS, 8'h02, RESP_OKAY);
      check("irq", 32'h0, {31'h0, irq});
    end
    $display("length code test done");
  endtask : t_lengths

  // All-zero line: activate drops, deactivate (all zeros, eight bits) appears
  task automatic t_pattern_swap();
    @(posedge aclk);
    far_zero <= 1'b1;
    axi_wr(ADDR_EVT_STS, 8'h03, RESP_OKAY);
    axi_wr(ADDR_EVT_MASK, 8'h01, RESP_OKAY);
    wait_irq();
    check("cpu_irq_n", 32'h0, {31'h0, cpu_irq_n});
    axi_rd(ADDR_IRQ_EN_STS, 8'h69, RESP_OKAY, "en_sts");
    check("cpu_irq_n", 32'h1, {31'h0, cpu_irq_n});
    axi_rd(ADDR_IRQ_EN_STS, 8'h61, RESP_OKAY, "en_sts again");
    axi_rd(ADDR_EVT_STS, 8'h03, RESP_OKAY, "evt_sts");
    axi_wr(ADDR_EVT_MASK, 8'h00, RESP_OKAY);
    check("irq masked", 32'h0, {31'h0, irq});
    axi_wr(ADDR_EVT_STS, 8'h01, RESP_OKAY);
    axi_rd(ADDR_EVT_STS, 8'h02, RESP_OKAY, "evt_sts sticky");
    axi_rd(ADDR_EVT_MASK, 8'h00, RESP_OKAY, "evt_mask");
    $display("pattern swap test done");
  endtask : t_pattern_swap

  // --------------------------------------------------------------------------
  // Clock and main sequence
  // --------------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    e1_mode = 1'b0;
    far_on = 1'b0;
    far_zero = 1'b0;
    far_period = 4'h5;
    s_axi_awaddr = 12'h0;
    s_axi_araddr = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_e1_hold();
    t_lengths();
    t_pattern_swap();
    report_and_stop();
  end
endmodule : inband_loopback_code_detector_tb_top
